// ---- rtl/alimc_pkg.sv ----
// Package for the left-channel line input mix control register bank.
// Assumes a simple byte-wide register port from the device control bus.
// Function
// - Register 0x14 bit 7 picks single-ended (0) or differential (1) mode.
// - Register 0x14 bits 6..3 set attenuation, 0 to -12 dB, 1.5 dB steps.
// - Any valid level code connects the input; 1111, the reset value, disconnects.
// - Register 0x14 bit 2 enables weak common-mode bias; resets to 0.
// - Register 0x14 bits 1..0 read zero; software writes zeros.
// - Register 0x15 bit 7 picks single-ended or differential mode; resets to 0.
// - Register 0x15 bits 6..3 set attenuation, 0 to -12 dB, 1.5 dB steps.
// - Valid level code connects the input; 1111, the reset value, disconnects.
// - Register 0x15 bits 2..0 read zero; software writes zeros.

package alimc_pkg;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SECOND_LEFT  = 8'h14;
    localparam logic [7:0] ADDR_FIRST_RIGHT  = 8'h15;
    localparam int         MODE_BIT          = 7;
    localparam int         LEVEL_MSB         = 6;
    localparam int         LEVEL_LSB         = 3;
    localparam int         BIAS_BIT          = 2;
    localparam logic [3:0] LEVEL_RESET       = 4'hf;
    localparam logic       MODE_RESET        = 1'b0;
    localparam logic       BIAS_RESET        = 1'b0;
    localparam logic       CONN_RESET        = 1'b0;
    localparam logic [7:0] RDATA_RESET       = 8'h00;
    localparam logic [3:0] LEVEL_MAX_VALID   = 4'h8;
    localparam logic [3:0] LEVEL_OFF         = 4'hf;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       diff_mode_select;
        logic [3:0] level;
    } alimc_route_s;

    typedef struct packed {
        alimc_route_s second_left;
        logic         bias_en;
        alimc_route_s first_right;
        logic         sl_conn;
        logic         fr_conn;
        logic [7:0]   rdata;
    } alimc_state_s;

endpackage : alimc_pkg

// ---- rtl/alimc_regs.sv ----
// Line input to left mixer control registers.
// Assumes the control bus presents one-cycle write and read strobes on mclk.
`timescale 1ns/1ps
`default_nettype none

module alimc_regs
(
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    output logic            second_left_line_input_diff,
    output logic      [3:0] second_left_line_input_level,
    output logic            second_left_line_input_connect,
    output logic            left_weak_bias_en,
    output logic            first_right_line_input_diff,
    output logic      [3:0] first_right_line_input_level,
    output logic            first_right_line_input_connect
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    alimc_pkg::alimc_state_s state;
    alimc_pkg::alimc_state_s next_state;

    // Codes up to the last valid step connect the input.
    function automatic logic level_connects(input logic [3:0] lvl);
        level_connects = (lvl <= alimc_pkg::LEVEL_MAX_VALID);
    endfunction : level_connects

    function automatic logic [7:0] pack_reg(input alimc_pkg::alimc_route_s r,
                                            input logic b);
        pack_reg = {r.diff_mode_select, r.level, b, 2'h0};
    endfunction : pack_reg

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        if (wr_en && addr == alimc_pkg::ADDR_SECOND_LEFT)
        begin
            next_state.second_left.diff_mode_select = wdata[alimc_pkg::MODE_BIT];
            next_state.second_left.level =
                wdata[alimc_pkg::LEVEL_MSB:alimc_pkg::LEVEL_LSB];
            next_state.bias_en = wdata[alimc_pkg::BIAS_BIT];
        end
        if (wr_en && addr == alimc_pkg::ADDR_FIRST_RIGHT)
        begin
            next_state.first_right.diff_mode_select = wdata[alimc_pkg::MODE_BIT];
            next_state.first_right.level =
                wdata[alimc_pkg::LEVEL_MSB:alimc_pkg::LEVEL_LSB];
        end
        if (rd_en)
        begin
            unique case (addr)
                alimc_pkg::ADDR_SECOND_LEFT:
                    next_state.rdata = pack_reg(state.second_left, state.bias_en);
                alimc_pkg::ADDR_FIRST_RIGHT:
                    next_state.rdata = pack_reg(state.first_right, 1'b0);
                default:
                    next_state.rdata = 8'h00;
            endcase
        end
        next_state.sl_conn = level_connects(next_state.second_left.level);
        next_state.fr_conn = level_connects(next_state.first_right.level);
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state.second_left.diff_mode_select <= alimc_pkg::MODE_RESET;
            state.second_left.level            <= alimc_pkg::LEVEL_RESET;
            state.bias_en                      <= alimc_pkg::BIAS_RESET;
            state.first_right.diff_mode_select <= alimc_pkg::MODE_RESET;
            state.first_right.level            <= alimc_pkg::LEVEL_RESET;
            state.sl_conn                      <= alimc_pkg::CONN_RESET;
            state.fr_conn                      <= alimc_pkg::CONN_RESET;
            state.rdata                        <= alimc_pkg::RDATA_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata                          = state.rdata;
    assign second_left_line_input_diff    = state.second_left.diff_mode_select;
    assign second_left_line_input_level   = state.second_left.level;
    assign second_left_line_input_connect = state.sl_conn;
    assign left_weak_bias_en              = state.bias_en;
    assign first_right_line_input_diff    = state.first_right.diff_mode_select;
    assign first_right_line_input_level   = state.first_right.level;
    assign first_right_line_input_connect = state.fr_conn;

endmodule : alimc_regs

`default_nettype wire

// ---- tb/alimc_regs_properties.sv ----
// Checker for the line input mix control registers.
// Assumes one mclk domain, rstn synchronous active low.
`timescale 1ns/1ps
`default_nettype none
module alimc_regs_chk (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       second_left_line_input_diff,
    input wire logic       second_left_line_input_connect,
    input wire logic       left_weak_bias_en,
    input wire logic       first_right_line_input_diff,
    input wire logic       first_right_line_input_connect,
    input wire logic [3:0] second_left_line_input_level,
    input wire logic [3:0] first_right_line_input_level
);
    wire [5:0] sl = {second_left_line_input_diff, second_left_line_input_level,
                     left_weak_bias_en};
    wire [4:0] fr = {first_right_line_input_diff, first_right_line_input_level};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_sl_write: assert property (wr_en && addr == 8'h14 |=> sl == $past(wdata[7:2]))
        else $error("second left write lost");
    a_fr_write: assert property (wr_en && addr == 8'h15 |=> fr == $past(wdata[7:3]))
        else $error("first right write lost");
    a_sl_connect: assert property (second_left_line_input_connect == (sl[4:1] <= 4'h8))
        else $error("second left connect wrong");
    a_fr_connect: assert property (first_right_line_input_connect == (fr[3:0] <= 4'h8))
        else $error("first right connect wrong");
    a_sl_read: assert property (rd_en && addr == 8'h14 |=> rdata == {$past(sl), 2'b00})
        else $error("second left read wrong");
    a_fr_read: assert property (rd_en && addr == 8'h15 |=> rdata == {$past(fr), 3'b000})
        else $error("first right read wrong");
    a_hold_quiet: assert property (!wr_en |=> $stable({sl, fr}))
        else $error("fields moved without write");
    a_rd_unmapped: assert property (rd_en && addr[7:1] != 7'h0a |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : alimc_regs_chk
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the line input mix control registers.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
    logic mclk = 0, rstn = 0, wr_en = 0, rd_en = 0, sd, sc, bias, fd, fc;
    logic [7:0] addr = 0, wdata = 0, rdata, d;
    logic [3:0] sl, fl, lv, rv;
    int n_fail = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    alimc_regs DUT (.mclk(mclk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .wdata(wdata),
        .rd_en(rd_en), .rdata(rdata), .second_left_line_input_diff(sd),
        .second_left_line_input_level(sl), .second_left_line_input_connect(sc),
        .left_weak_bias_en(bias), .first_right_line_input_diff(fd),
        .first_right_line_input_level(fl), .first_right_line_input_connect(fc));
    task automatic bus(input logic [7:0] a, input logic [7:0] v, input logic w);
        @(negedge mclk);
        {addr, wdata, wr_en, rd_en} = {a, v, w, !w};
        @(negedge mclk);
        {wr_en, rd_en} = 2'b00;
    endtask : bus
    task automatic t_reset;
        `CHK("reset fields", 13'h0f1e, {sd, sl, sc, bias, fd, fl, fc})
        bus(8'h14, 8'h00, 0);
        `CHK("reset 0x14", 8'h78, rdata)
        bus(8'h15, 8'h00, 0);
        `CHK("reset 0x15", 8'h78, rdata)
        $display("reset test done");
    endtask : t_reset
    task automatic t_codes;
        for (int i = 0; i < 16; i++)
        begin
            if (i > 8 && i < 15) continue;
            lv = i[3:0];
            rv = (i == 15) ? 4'hf : 4'h8 - lv;
            d = {i[0], lv, i[1], 2'b00};
            bus(8'h14, d, 1);
            bus(8'h15, {~d[7], rv, 3'b000}, 1);
            `CHK("second left", {d[7:2], i < 9}, {sd, sl, bias, sc})
            `CHK("first right", {~d[7], rv, i < 9}, {fd, fl, fc})
            bus(8'h14, 8'h00, 0);
            `CHK("read 0x14", {d[7:2], 2'b00}, rdata)
            bus(8'h15, 8'h00, 0);
            `CHK("read 0x15", {~d[7], rv, 3'b000}, rdata)
        end
        $display("code test done");
    endtask : t_codes
    task automatic t_unmapped;
        bus(8'h16, 8'h00, 1);
        `CHK("after unmapped", 6'h3f, {sd, sl, bias})
        `CHK("after unmapped right", 5'h0f, {fd, fl})
        bus(8'h16, 8'h00, 0);
        `CHK("unmapped read", 8'h00, rdata)
        $display("unmapped test done");
    endtask : t_unmapped
    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (16) @(negedge mclk);
        rstn = 1;
        t_reset();
        t_codes();
        t_unmapped();
        test_done();
    end
    initial
    begin
        #20us;
        n_fail++;
        test_done();
    end
endmodule : tb_top
bind alimc_regs alimc_regs_chk u_chk (.*);
`default_nettype wire
